/* inc/lp_sdram_pkg.sv */
// Purpose: shared constants and carrier types of the low-power sdram pin interface
// Assumes: one clock domain, synchronous active-high reset
// Notes: widths and encodings are the device's; reset values of the mode word are ours
package lp_sdram_pkg;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int ROW_W = 11;
  localparam int COL_W = 8;
  localparam int DATA_W = 32;
  localparam int MASK_W = 4;
  localparam int MODE_W = 12;
  localparam int MADDR_W = 1 + ROW_W + COL_W;

  // ----------------------------------------------------------------
  // command codes {ras_n, cas_n, we_n}, qualified by chip select low
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_LMR = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // ----------------------------------------------------------------
  // address and mode word fields
  // ----------------------------------------------------------------
  localparam int AP_BIT = 10;
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_OPM_LSB = 7;
  localparam int MR_WB_BIT = 9;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] CL_1 = 3'h1;
  localparam logic [2:0] CL_2 = 3'h2;
  localparam logic [2:0] CL_3 = 3'h3;
  localparam logic [MODE_W-1:0] MODE_RST = 12'h020;

  // ----------------------------------------------------------------
  // power states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    PW_RUN = 5'h01,
    PW_SUSPEND = 5'h02,
    PW_ACT_PD = 5'h04,
    PW_PRE_PD = 5'h08,
    PW_SELF_REF = 5'h10
  } pwr_e;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    pwr_e pwr;
    logic inbuf_en;
    logic [1:0] bank_open;
    logic burst_active;
    logic [MODE_W-1:0] mode_value;
  } status_s;

  typedef struct packed {
    pwr_e pwr;
    logic [MODE_W-1:0] mode;
    logic [1:0] open;
    logic [1:0][ROW_W-1:0] row;
    logic bact;
    logic bwr;
    logic bbank;
    logic bil;
    logic bfull;
    logic bap;
    logic [COL_W-1:0] bstart;
    logic [COL_W-1:0] bcnt;
    logic [COL_W-1:0] bmask;
    logic [1:0] pv;
    logic [1:0][DATA_W-1:0] pd;
    logic [MASK_W-1:0] mask_d;
    logic [DATA_W-1:0] dq;
    logic [MASK_W-1:0] oe;
  } core_state_s;

  localparam core_state_s STATE_RST = '{
    pwr: PW_RUN, mode: MODE_RST, default: '0
  };

endpackage

/* verilog/lp_sdram_core.sv */
// Purpose: pin-level command, burst and data logic of a two-bank 32-bit low-power sdram
// Assumes: controller follows the power-up sequence and mode-load timing
// Notes: clock-enable wake-up is taken on the first edge with it high
//
// What this block does
// [R1] all pins sampled on rising clock edge
// [R2] each clock-enabled edge advances burst, updates output registers
// [R3] low clock-enable enters power-down, self refresh, suspend
// [R4] clock-enable synchronous, wakes device from power-down
// [R5] input buffers off in power-down, self refresh
// [R6] controller may tie clock-enable permanently high
// [R7] chip select high masks every command
// [R8] chip select and strobes form command
// [R9] write byte mask high keeps stored byte
// [R10] read byte mask floats byte two clocks later
// [R11] four masks, one per data byte
// [R12] bank pick selects bank, is mode bit
// [R13] row from bits 0-10, column 0-7
// [R14] bit 10 on read/write requests auto-precharge
// [R15] precharge bit 10 high closes all banks
// [R16] mode load stores address with bank pick
// [R17] burst lengths 1, 2, 4, 8, page
// [R18] two banks, 2048 rows, 256 columns
// [R19] controller initialises before operational commands
// [R20] mode word field layout
// [R21] standard command encoding of four strobes
`timescale 1ns/1ps
`default_nettype none

module lp_sdram_core (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // command pins
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic i_bank_pick,
  input wire logic [lp_sdram_pkg::ROW_W-1:0] i_addr_in,
  input wire logic [lp_sdram_pkg::MASK_W-1:0] i_byte_mask,
  // data bus, split into in, out and per-byte enable
  input wire logic [lp_sdram_pkg::DATA_W-1:0] i_dq,
  output logic [lp_sdram_pkg::DATA_W-1:0] o_dq,
  output logic [lp_sdram_pkg::MASK_W-1:0] o_dq_oe,
  // status
  output lp_sdram_pkg::status_s o_status
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [lp_sdram_pkg::COL_W-1:0] col_at(
    input logic [lp_sdram_pkg::COL_W-1:0] start,
    input logic [lp_sdram_pkg::COL_W-1:0] k,
    input logic [lp_sdram_pkg::COL_W-1:0] m,
    input logic il
  );
    logic [lp_sdram_pkg::COL_W-1:0] step;
    step = il ? (start ^ k) : lp_sdram_pkg::COL_W'(start + k);
    // burst wraps inside its aligned block
    return (start & ~m) | (step & m);
  endfunction

  function automatic logic [lp_sdram_pkg::COL_W-1:0] len_mask(input logic [2:0] bl);
    logic [lp_sdram_pkg::COL_W-1:0] m;
    m = 8'h00;
    unique case (bl)
      lp_sdram_pkg::BL_2: m = 8'h01;
      lp_sdram_pkg::BL_4: m = 8'h03;
      lp_sdram_pkg::BL_8: m = 8'h07;
      lp_sdram_pkg::BL_PAGE: m = 8'hFF;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  localparam int DEPTH = 2 ** lp_sdram_pkg::MADDR_W;

  logic [lp_sdram_pkg::DATA_W-1:0] mem [0:DEPTH-1]; // see [R18]

  lp_sdram_pkg::core_state_s r_reg;
  lp_sdram_pkg::core_state_s r_next;

  logic [2:0] cmd;
  logic take;
  logic advance;
  logic wr_now;
  logic rd_now;
  logic [lp_sdram_pkg::MADDR_W-1:0] acc_addr;
  logic [lp_sdram_pkg::DATA_W-1:0] rd_data;
  logic out_v;
  logic [lp_sdram_pkg::DATA_W-1:0] out_d;
  logic [2:0] bl;
  logic [2:0] cl;
  logic [lp_sdram_pkg::COL_W-1:0] m_rd;
  logic [lp_sdram_pkg::COL_W-1:0] m_cmd;
  logic [lp_sdram_pkg::COL_W-1:0] col;
  logic bank;
  logic last;

  assign rd_data = mem[acc_addr];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    cmd = {i_ras_n, i_cas_n, i_we_n}; // see [R8] [R21]
    bl = r_reg.mode[lp_sdram_pkg::MR_BL_LSB +: 3];
    cl = r_reg.mode[lp_sdram_pkg::MR_CL_LSB +: 3];
    m_rd = len_mask(bl); // see [R17]
    wr_now = 1'b0;
    rd_now = 1'b0;
    col = '0;
    bank = 1'b0;
    last = 1'b0;
    m_cmd = '0;
    // decoder only listens in the run state and while the clock is enabled
    take = (r_reg.pwr == lp_sdram_pkg::PW_RUN) && i_cke && !i_cs_n; // see [R1] [R5] [R7]
    // a low clock-enable freezes this edge, which is the suspend
    advance = r_reg.bact && i_cke &&
      (r_reg.pwr == lp_sdram_pkg::PW_RUN || r_reg.pwr == lp_sdram_pkg::PW_SUSPEND); // see [R2] [R3]

    // burst in flight, one column per enabled edge
    if (advance) begin
      col = col_at(r_reg.bstart, r_reg.bcnt, r_reg.bmask, r_reg.bil); // see [R2]
      bank = r_reg.bbank;
      wr_now = r_reg.bwr;
      rd_now = !r_reg.bwr;
      last = (r_reg.bcnt == r_reg.bmask) && !r_reg.bfull;
      r_next.bcnt = lp_sdram_pkg::COL_W'(r_reg.bcnt + 8'h01);
      if (last) begin
        r_next.bact = 1'b0;
        if (r_reg.bap) begin
          r_next.open[r_reg.bbank] = 1'b0; // see [R14]
        end
      end
    end

    // command decode
    if (take) begin
      unique case (cmd)
        lp_sdram_pkg::CMD_ACT: begin
          r_next.open[i_bank_pick] = 1'b1; // see [R12]
          r_next.row[i_bank_pick] = i_addr_in; // see [R13]
        end
        lp_sdram_pkg::CMD_RD, lp_sdram_pkg::CMD_WR: begin
          // a new access cuts off any burst in flight
          wr_now = (cmd == lp_sdram_pkg::CMD_WR);
          rd_now = (cmd == lp_sdram_pkg::CMD_RD);
          bank = i_bank_pick; // see [R12]
          col = i_addr_in[lp_sdram_pkg::COL_W-1:0]; // see [R13]
          m_cmd = (wr_now && r_reg.mode[lp_sdram_pkg::MR_WB_BIT]) ? 8'h00 : m_rd;
          r_next.bwr = wr_now;
          r_next.bbank = i_bank_pick;
          r_next.bstart = col;
          r_next.bcnt = 8'h01;
          r_next.bmask = m_cmd;
          // interleave ignored for single-word bursts
          r_next.bil = r_reg.mode[lp_sdram_pkg::MR_BT_BIT] && (m_cmd != 8'h00);
          r_next.bfull = (bl == lp_sdram_pkg::BL_PAGE) && (m_cmd != 8'h00);
          r_next.bap = i_addr_in[lp_sdram_pkg::AP_BIT]; // see [R14]
          r_next.bact = (m_cmd != 8'h00);
          if ((m_cmd == 8'h00) && i_addr_in[lp_sdram_pkg::AP_BIT]) begin
            r_next.open[i_bank_pick] = 1'b0; // see [R14]
          end
        end
        lp_sdram_pkg::CMD_PRE: begin
          r_next.bact = 1'b0;
          if (i_addr_in[lp_sdram_pkg::AP_BIT]) begin
            r_next.open = 2'b00; // see [R15]
          end else begin
            r_next.open[i_bank_pick] = 1'b0; // see [R15]
          end
        end
        lp_sdram_pkg::CMD_BST: begin
          r_next.bact = 1'b0;
        end
        lp_sdram_pkg::CMD_LMR: begin
          // bank pick lands in the top bit of the stored word
          r_next.mode = {i_bank_pick, i_addr_in}; // see [R16] [R20]
        end
        lp_sdram_pkg::CMD_REF, lp_sdram_pkg::CMD_NOP: begin
          // refresh of the array is implicit in this storage
        end
      endcase
    end

    acc_addr = {bank, r_reg.row[bank], col};

    // read pipeline for latencies one to three, frozen while suspended
    out_v = 1'b0;
    out_d = r_reg.dq;
    if (i_cke) begin
      r_next.pv = {r_reg.pv[0], rd_now};
      r_next.pd = {r_reg.pd[0], rd_data};
      unique case (cl)
        lp_sdram_pkg::CL_1: begin
          out_v = rd_now;
          out_d = rd_data;
        end
        lp_sdram_pkg::CL_3: begin
          out_v = r_reg.pv[1];
          out_d = r_reg.pd[1];
        end
        default: begin
          out_v = r_reg.pv[0];
          out_d = r_reg.pd[0];
        end
      endcase
      r_next.dq = out_d; // see [R2]
      // mask sampled last edge floats this byte from the next edge on
      r_next.oe = {lp_sdram_pkg::MASK_W{out_v}} & ~r_reg.mask_d; // see [R10] [R11]
    end
    r_next.mask_d = i_byte_mask;

    // power state
    unique case (r_reg.pwr)
      lp_sdram_pkg::PW_RUN: begin
        if (!i_cke) begin // see [R3]
          if (!i_cs_n && cmd == lp_sdram_pkg::CMD_REF && r_reg.open == 2'b00) begin
            r_next.pwr = lp_sdram_pkg::PW_SELF_REF;
          end else if (r_reg.bact || (|r_reg.pv)) begin
            r_next.pwr = lp_sdram_pkg::PW_SUSPEND;
          end else if (|r_reg.open) begin
            r_next.pwr = lp_sdram_pkg::PW_ACT_PD;
          end else begin
            r_next.pwr = lp_sdram_pkg::PW_PRE_PD;
          end
        end
      end
      lp_sdram_pkg::PW_SUSPEND, lp_sdram_pkg::PW_ACT_PD,
      lp_sdram_pkg::PW_PRE_PD, lp_sdram_pkg::PW_SELF_REF: begin
        // no clock edge is needed to notice wake-up beyond this one
        if (i_cke) begin
          r_next.pwr = lp_sdram_pkg::PW_RUN; // see [R4]
        end
      end
      default: r_next.pwr = lp_sdram_pkg::PW_RUN;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      r_reg <= lp_sdram_pkg::STATE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // array is not reset, its content is undefined at power-up anyway
  always_ff @(posedge i_mclk) begin
    for (int b = 0; b < lp_sdram_pkg::MASK_W; b++) begin
      if (!i_sys_rst && wr_now && !i_byte_mask[b]) begin // see [R9] [R11]
        mem[acc_addr][b*8 +: 8] <= i_dq[b*8 +: 8];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_dq = r_reg.dq;
  assign o_dq_oe = r_reg.oe;
  // one driver for the whole status word
  assign o_status = '{
    pwr: r_reg.pwr,
    inbuf_en: (r_reg.pwr == lp_sdram_pkg::PW_RUN) ||
      (r_reg.pwr == lp_sdram_pkg::PW_SUSPEND), // see [R5]
    bank_open: r_reg.open,
    burst_active: r_reg.bact,
    mode_value: r_reg.mode
  };

endmodule

`default_nettype wire

/* verification/lp_sdram_chk.sv */
// Purpose: port checks of the sdram pin block
// Assumes: one clock, synchronous reset
// Notes: bound to every lp_sdram_core
`timescale 1ns/1ps
`default_nettype none
module lp_sdram_chk (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // pins
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic i_bank_pick,
  input wire logic [lp_sdram_pkg::ROW_W-1:0] i_addr_in,
  input wire logic [lp_sdram_pkg::MASK_W-1:0] i_byte_mask,
  input wire logic [lp_sdram_pkg::DATA_W-1:0] i_dq,
  // outputs
  input wire logic [lp_sdram_pkg::DATA_W-1:0] o_dq,
  input wire logic [lp_sdram_pkg::MASK_W-1:0] o_dq_oe,
  input wire lp_sdram_pkg::status_s o_status
);
  logic tk;
  logic pd;
  logic [2:0] op;
  assign op = {i_ras_n, i_cas_n, i_we_n};
  assign tk = i_cke && !i_cs_n && o_status.pwr == lp_sdram_pkg::PW_RUN;
  assign pd = o_status.pwr inside {lp_sdram_pkg::PW_ACT_PD, lp_sdram_pkg::PW_PRE_PD,
    lp_sdram_pkg::PW_SELF_REF};
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_idle;
    !tk |=> $stable(o_status.mode_value);
  endproperty
  a_idle: assert property (p_idle) else $error("mode changed with no command");
  property p_lmr;
    tk && op == lp_sdram_pkg::CMD_LMR |=>
      o_status.mode_value == {$past(i_bank_pick), $past(i_addr_in)};
  endproperty
  a_lmr: assert property (p_lmr) else $error("mode load value wrong");
  property p_act;
    tk && op == lp_sdram_pkg::CMD_ACT |=> o_status.bank_open[$past(i_bank_pick)];
  endproperty
  a_act: assert property (p_act) else $error("activate did not open bank");
  property p_gate;
    $past(i_cke) && $past(i_cke, 2) && $past(o_status.pwr, 2) == lp_sdram_pkg::PW_RUN
      |-> (o_dq_oe & $past(i_byte_mask, 2)) == 4'h0;
  endproperty
  a_gate: assert property (p_gate) else $error("masked byte driven");
  property p_lat;
    tk && op == lp_sdram_pkg::CMD_RD && i_byte_mask == 4'h0 &&
      o_status.mode_value[lp_sdram_pkg::MR_CL_LSB +: 3] == lp_sdram_pkg::CL_2 ##1 i_cke
      |=> o_dq_oe == 4'hF;
  endproperty
  a_lat: assert property (p_lat) else $error("read word not driven");
  property p_buf;
    o_status.inbuf_en == !pd;
  endproperty
  a_buf: assert property (p_buf) else $error("input buffer state wrong");
  property p_sleep;
    o_status.pwr == lp_sdram_pkg::PW_RUN && !i_cke && i_cs_n && $past(i_cs_n) &&
      $past(i_cs_n, 2) && $past(i_cke) && o_status.bank_open == 2'h0 &&
      !o_status.burst_active && o_dq_oe == 4'h0 |=> o_status.pwr == lp_sdram_pkg::PW_PRE_PD;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no precharge power-down");
  property p_wake;
    pd && i_cke |=> o_status.pwr == lp_sdram_pkg::PW_RUN;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on clock enable");
endmodule
bind lp_sdram_core lp_sdram_chk u_chk (
  .i_mclk, .i_sys_rst, .i_cke, .i_cs_n, .i_ras_n, .i_cas_n, .i_we_n, .i_bank_pick,
  .i_addr_in, .i_byte_mask, .i_dq, .o_dq, .o_dq_oe, .o_status
);
`default_nettype wire

/* verification/lp_sdram_ctrl_model.sv */
// Purpose: memory controller model driving the sdram pins
// Assumes: tasks entered just after a rising edge
// Notes: data bus level resolved in the bench
`timescale 1ns/1ps
`default_nettype none
module lp_sdram_ctrl_model #(
  parameter int INIT_CYC = 12500
) (
  // clock
  input wire logic i_mclk,
  // command pins
  output logic o_cke,
  output logic o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic o_bank_pick,
  output logic [10:0] o_addr_in,
  output logic [3:0] o_byte_mask,
  // write data and its enable
  output logic [31:0] o_dq,
  output logic o_dq_en
);
  initial begin
    o_cke = 1'b1;
    o_cs_n = 1'b1;
    {o_ras_n, o_cas_n, o_we_n} = 3'h7;
    o_bank_pick = 1'b0;
    o_addr_in = 11'h000;
    o_byte_mask = 4'h0;
    o_dq = 32'h0;
    o_dq_en = 1'b0;
  end
  task automatic cmd(input logic [2:0] c, input logic b, input logic [10:0] a,
    input logic [3:0] m = 4'h0, input logic [31:0] d = 32'h0, input logic en = 1'b0,
    input logic csn = 1'b0);
    o_cs_n = csn;
    {o_ras_n, o_cas_n, o_we_n} = c;
    o_bank_pick = b;
    o_addr_in = a;
    o_byte_mask = m;
    o_dq = d;
    o_dq_en = en;
    @(posedge i_mclk);
    #1;
    o_cs_n = 1'b1;
    o_byte_mask = 4'h0;
    o_dq_en = 1'b0;
  endtask
  task automatic cke(input logic v);
    o_cke = v;
    @(posedge i_mclk);
    #1;
  endtask
  task automatic sref();
    o_cke = 1'b0;
    cmd(lp_sdram_pkg::CMD_REF, 1'b0, 11'h000);
  endtask
  // quiet wait first, since the array is not usable before it
  task automatic init();
    repeat (INIT_CYC) @(posedge i_mclk);
    #1;
    cmd(lp_sdram_pkg::CMD_PRE, 1'b0, 11'h400);
    cmd(lp_sdram_pkg::CMD_REF, 1'b0, 11'h000);
    cmd(lp_sdram_pkg::CMD_REF, 1'b0, 11'h000);
  endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Purpose: self-checking bench of the sdram pin block
// Assumes: 125 MHz clock, controller model on the pins
// Notes: array content checked only where written first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [31:0] A1 = 32'h55667788;
  localparam logic [31:0] B0 = 32'hA1B2C3D4;
  localparam logic [31:0] B1 = 32'hE5F60718;
  localparam logic [31:0] E1 = (B1 & 32'hFFFF00FF) | (A1 & 32'h0000FF00);
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_bank_pick, en;
  logic [10:0] i_addr_in;
  logic [3:0] i_byte_mask, o_dq_oe;
  logic [31:0] drv, dq_w, oe32, o_dq;
  logic [31:0] dq_last = 32'h0;
  lp_sdram_pkg::status_s st;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  lp_sdram_ctrl_model cm (.i_mclk(i_mclk), .o_cke(i_cke), .o_cs_n(i_cs_n), .o_ras_n(i_ras_n),
    .o_cas_n(i_cas_n), .o_we_n(i_we_n), .o_bank_pick(i_bank_pick), .o_addr_in(i_addr_in),
    .o_byte_mask(i_byte_mask), .o_dq(drv), .o_dq_en(en));
  lp_sdram_core uut (.i_mclk, .i_sys_rst, .i_cke, .i_cs_n, .i_ras_n, .i_cas_n, .i_we_n,
    .i_bank_pick, .i_addr_in, .i_byte_mask, .i_dq(dq_w), .o_dq, .o_dq_oe, .o_status(st));
  // released bytes flip each cycle so a stale level never matches
  assign oe32 = {{8{o_dq_oe[3]}}, {8{o_dq_oe[2]}}, {8{o_dq_oe[1]}}, {8{o_dq_oe[0]}}};
  assign dq_w = (o_dq & oe32) | (~oe32 & (en ? drv : ~dq_last));
  always @(posedge i_mclk) dq_last <= dq_w;
  initial begin
    forever #4 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic rd2(input logic [10:0] a, input logic [3:0] m, input logic [31:0] e0, e1);
    logic [31:0] k;
    k = {{8{~m[3]}}, {8{~m[2]}}, {8{~m[1]}}, {8{~m[0]}}};
    cm.cmd(lp_sdram_pkg::CMD_RD, 1'b0, a, m);
    wt(1);
    check("oe0", o_dq_oe, m ^ 4'hF);
    check("dq0", o_dq & k, e0 & k);
    wt(1);
    check("dq1", o_dq, e1);
    wt(1);
    check("oe_end", o_dq_oe, 4'h0);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    wt(2);
    i_sys_rst = 1'b0;
    check("mode_rst", st.mode_value, 12'h020);
    check("pwr_rst", st.pwr, lp_sdram_pkg::PW_RUN);
    cm.init();
    cm.cmd(lp_sdram_pkg::CMD_LMR, 1'b1, 11'h011);
    check("mode_bp", st.mode_value, 12'h811);
    cm.cmd(lp_sdram_pkg::CMD_LMR, 1'b0, 11'h000, 4'h0, 32'h0, 1'b0, 1'b1);
    check("mode_cs", st.mode_value, 12'h811);
    cm.cmd(lp_sdram_pkg::CMD_LMR, 1'b0, 11'h021);
    check("mode", st.mode_value, 12'h021);
    cm.cmd(lp_sdram_pkg::CMD_ACT, 1'b0, 11'h005);
    check("open0", st.bank_open, 2'h1);
    cm.cmd(lp_sdram_pkg::CMD_WR, 1'b0, 11'h004, 4'h0, 32'h11223344, 1'b1);
    cm.cmd(lp_sdram_pkg::CMD_NOP, 1'b0, 11'h000, 4'h0, A1, 1'b1);
    cm.cmd(lp_sdram_pkg::CMD_WR, 1'b0, 11'h004, 4'h0, B0, 1'b1);
    cm.cmd(lp_sdram_pkg::CMD_NOP, 1'b0, 11'h000, 4'h2, B1, 1'b1);
    rd2(11'h004, 4'h1, B0, E1);
    rd2(11'h005, 4'h0, E1, B0);
    cm.cmd(lp_sdram_pkg::CMD_ACT, 1'b1, 11'h007);
    check("open2", st.bank_open, 2'h3);
    cm.cmd(lp_sdram_pkg::CMD_PRE, 1'b0, 11'h000);
    check("pre_one", st.bank_open, 2'h2);
    cm.cmd(lp_sdram_pkg::CMD_PRE, 1'b0, 11'h400);
    check("pre_all", st.bank_open, 2'h0);
    cm.cmd(lp_sdram_pkg::CMD_ACT, 1'b0, 11'h005);
    rd2(11'h404, 4'h0, B0, E1);
    check("auto_pre", st.bank_open, 2'h0);
    cm.cmd(lp_sdram_pkg::CMD_ACT, 1'b1, 11'h007);
    cm.cke(1'b0);
    check("act_pd", st.pwr, lp_sdram_pkg::PW_ACT_PD);
    check("buf_off", st.inbuf_en, 1'b0);
    cm.cmd(lp_sdram_pkg::CMD_PRE, 1'b0, 11'h400);
    check("pd_ign", st.bank_open, 2'h2);
    cm.cke(1'b1);
    check("wake", st.pwr, lp_sdram_pkg::PW_RUN);
    cm.cmd(lp_sdram_pkg::CMD_PRE, 1'b0, 11'h400);
    wt(2);
    cm.cke(1'b0);
    check("pre_pd", st.pwr, lp_sdram_pkg::PW_PRE_PD);
    cm.cke(1'b1);
    cm.sref();
    check("sref", st.pwr, lp_sdram_pkg::PW_SELF_REF);
    cm.cke(1'b1);
    check("sref_out", st.pwr, lp_sdram_pkg::PW_RUN);
    complete_run();
  end
endmodule
`default_nettype wire
